/* fwe_consts.svh */
// Constants for the flash write and erase control block
`ifndef FWE_CONSTS_SVH
`define FWE_CONSTS_SVH

`define FWE_ADDR_STORE_CTRL 8'h8f
`define FWE_ADDR_LIMIT 8'hb7
`define FWE_ADDR_FLASH_CTRL 8'hb7
`define FWE_PAGE_LIMIT 4'hf
`define FWE_PAGE_CTRL 4'h0

`define FWE_RST_STORE_CTRL 8'h00
`define FWE_RST_LIMIT 8'h00
`define FWE_RST_FLASH_CTRL 8'h80

`define FWE_BIT_ONE_SHOT 7
`define FWE_BIT_READ_ALWAYS 6
`define FWE_BIT_WE_GATE 0
`define FWE_BIT_SCRATCH 2
`define FWE_BIT_PAGE_ERASE 1
`define FWE_BIT_STORE_WR 0

`define FWE_LIMIT_LOW 8'h00
`define FWE_PAGE_MSB 15
`define FWE_PAGE_LSB 9
`define FWE_LOCK_PAGE 7'h7e
`define FWE_ZERO_BYTE 8'h00
`define FWE_ST_BUSY_BIT 1

`endif

/* fwe_pkg.sv */
// Types shared by the flash write and erase control block
package fwe_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fwe_sfr_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [15:0] pc;
  } fwe_mx_req_t;

  typedef struct packed {
    logic prog;
    logic erase;
    logic read;
    logic scratch;
    logic [15:0] addr;
    logic [7:0] data;
  } fwe_fl_cmd_t;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } fwe_xram_t;

  typedef enum logic [1:0] {
    FWE_IDLE = 2'b01,
    FWE_BUSY = 2'b10
  } fwe_state_e_t;

  typedef struct packed {
    fwe_state_e_t st;
    logic [7:0] limit_hi;
    logic limit_taken;
    logic one_shot;
    logic read_always;
    logic we_gate;
    logic scratch;
    logic page_erase;
    logic store_wr;
    logic [7:0] sfr_rdata;
    logic rd_pend;
    logic rd_valid;
    logic [7:0] rd_data;
    logic sense_off;
    logic refused;
    fwe_fl_cmd_t cmd;
    fwe_xram_t xram;
  } fwe_state_t;

endpackage : fwe_pkg

/* fwe_guard.sv */
// Access permission check for flash reads, writes and erases
`timescale 1ns/1ps
`default_nettype none
`include "fwe_consts.svh"

module fwe_guard (
  input wire logic [7:0] limit_hi,
  input wire logic [15:0] pc,
  input wire logic [15:0] addr,
  input wire logic scratch,
  input wire logic erase,
  output logic [15:0] limit_addr,
  output logic permit
);

  logic upper_code;
  logic lower_target;
  logic lock_page;

  assign limit_addr = {limit_hi, `FWE_LIMIT_LOW};
  assign upper_code = (pc >= limit_addr);
  // Scratchpad is outside program memory, so the limit does not apply
  assign lower_target = !scratch && (addr < limit_addr);
  assign lock_page = !scratch &&
    (addr[`FWE_PAGE_MSB:`FWE_PAGE_LSB] == `FWE_LOCK_PAGE);

  always_comb begin
    permit = 1'b1;
    if (upper_code && lower_target) begin
      permit = 1'b0;
    end
    if (erase && lock_page) begin
      permit = 1'b0;
    end
  end

endmodule : fwe_guard
`default_nettype wire

/* fwe_top.sv */
// Flash write and erase control with its special-function registers
`timescale 1ns/1ps
`default_nettype none
`include "fwe_consts.svh"

module fwe_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire fwe_pkg::fwe_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire fwe_pkg::fwe_mx_req_t mx_req,
  output logic busy,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic refused,
  output fwe_pkg::fwe_fl_cmd_t fl_cmd,
  input wire logic fl_done,
  input wire logic fl_rvalid,
  input wire logic [7:0] fl_rdata,
  output logic one_shot_enable,
  output logic read_always_enable,
  output logic sense_off,
  output fwe_pkg::fwe_xram_t xram_wr
);

  fwe_pkg::fwe_state_t s;
  fwe_pkg::fwe_state_t next_s;
  logic [15:0] limit_addr;
  logic permit;
  logic is_erase;

  assign is_erase = s.page_erase && s.store_wr;

  fwe_guard u_guard (
    .limit_hi(s.limit_hi),
    .pc(mx_req.pc),
    .addr(mx_req.addr),
    .scratch(s.scratch),
    .erase(is_erase && mx_req.wr),
    .limit_addr(limit_addr),
    .permit(permit)
  );

  // Register decode helpers
  logic sel_store;
  logic sel_limit;
  logic sel_flash;

  always_comb begin
    sel_store = 1'b0;
    sel_limit = 1'b0;
    sel_flash = 1'b0;
    if (sfr_req.addr == `FWE_ADDR_STORE_CTRL &&
        sfr_req.page == `FWE_PAGE_CTRL) begin
      sel_store = 1'b1;
    end else if (sfr_req.addr == `FWE_ADDR_LIMIT &&
                 sfr_req.page == `FWE_PAGE_LIMIT) begin
      sel_limit = 1'b1;
    end else if (sfr_req.addr == `FWE_ADDR_FLASH_CTRL &&
                 sfr_req.page == `FWE_PAGE_CTRL) begin
      sel_flash = 1'b1;
    end
  end

  always_comb begin
    next_s = s;
    // One-cycle pulses fall back each cycle; the array read strobe falls back to read_always
    next_s.rd_valid = 1'b0;
    next_s.sense_off = 1'b0;
    next_s.refused = 1'b0;
    next_s.cmd.prog = 1'b0;
    next_s.cmd.erase = 1'b0;
    next_s.cmd.read = s.read_always;
    next_s.xram.wr = 1'b0;

    // Register reads; unmapped addresses read zero
    if (sfr_req.rd) begin
      next_s.sfr_rdata = `FWE_ZERO_BYTE;
      if (sel_store) begin
        next_s.sfr_rdata[`FWE_BIT_SCRATCH] = s.scratch;
        next_s.sfr_rdata[`FWE_BIT_PAGE_ERASE] = s.page_erase;
        next_s.sfr_rdata[`FWE_BIT_STORE_WR] = s.store_wr;
      end else if (sel_limit) begin
        next_s.sfr_rdata = s.limit_hi;
      end else if (sel_flash) begin
        next_s.sfr_rdata[`FWE_BIT_ONE_SHOT] = s.one_shot;
        next_s.sfr_rdata[`FWE_BIT_READ_ALWAYS] = s.read_always;
        next_s.sfr_rdata[`FWE_BIT_WE_GATE] = s.we_gate;
      end
    end

    // Register writes
    if (sfr_req.wr) begin
      if (sel_store) begin
        // Upper bits are simply not stored
        next_s.scratch = sfr_req.wdata[`FWE_BIT_SCRATCH];
        next_s.page_erase = sfr_req.wdata[`FWE_BIT_PAGE_ERASE];
        next_s.store_wr = sfr_req.wdata[`FWE_BIT_STORE_WR];
      end else if (sel_limit) begin
        if (!s.limit_taken) begin
          next_s.limit_hi = sfr_req.wdata;
          next_s.limit_taken = 1'b1;
        end
      end else if (sel_flash) begin
        next_s.one_shot = sfr_req.wdata[`FWE_BIT_ONE_SHOT];
        next_s.read_always = sfr_req.wdata[`FWE_BIT_READ_ALWAYS];
        next_s.we_gate = sfr_req.wdata[`FWE_BIT_WE_GATE];
      end
    end

    // Read data returning from the array
    if (s.rd_pend && fl_rvalid) begin
      next_s.rd_pend = 1'b0;
      next_s.rd_valid = 1'b1;
      next_s.rd_data = fl_rdata;
      next_s.sense_off = s.one_shot;
    end

    case (s.st)
      fwe_pkg::FWE_IDLE: begin
        if (mx_req.wr) begin
          if (!s.store_wr) begin
            next_s.xram.wr = 1'b1;
            next_s.xram.addr = mx_req.addr;
            next_s.xram.data = mx_req.wdata;
          end else if (s.we_gate && permit) begin
            // Erase ignores the data byte
            next_s.cmd.erase = s.page_erase;
            next_s.cmd.prog = !s.page_erase;
            next_s.cmd.scratch = s.scratch;
            next_s.cmd.addr = mx_req.addr;
            next_s.cmd.data = mx_req.wdata;
            next_s.st = fwe_pkg::FWE_BUSY;
          end else begin
            // Nothing reaches the array or other registers
            next_s.refused = 1'b1;
          end
        end else if (mx_req.rd && !s.rd_pend) begin
          if (permit) begin
            next_s.cmd.read = 1'b1;
            next_s.cmd.scratch = s.scratch;
            next_s.cmd.addr = mx_req.addr;
            next_s.rd_pend = 1'b1;
          end else begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data = `FWE_ZERO_BYTE;
          end
        end
      end
      fwe_pkg::FWE_BUSY: begin
        // Requests while busy are dropped; the core stalls on busy
        if (fl_done) begin
          next_s.st = fwe_pkg::FWE_IDLE;
        end
      end
      default: begin
        next_s.st = fwe_pkg::FWE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s <= '0;
      s.st <= fwe_pkg::FWE_IDLE;
      s.limit_hi <= `FWE_RST_LIMIT;
      s.one_shot <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sfr_rdata = s.sfr_rdata;
  // One-hot state bit keeps busy straight from a flop
  assign busy = s.st[`FWE_ST_BUSY_BIT];
  assign rd_valid = s.rd_valid;
  assign rd_data = s.rd_data;
  assign refused = s.refused;
  assign fl_cmd = s.cmd;
  assign one_shot_enable = s.one_shot;
  assign read_always_enable = s.read_always;
  assign sense_off = s.sense_off;
  assign xram_wr = s.xram;

endmodule : fwe_top
`default_nettype wire

/* fwe_top_sva.sv */
// Port assertions for the flash write and erase control block
`timescale 1ns/1ps
`default_nettype none
module fwe_top_sva (
  input wire logic core_clk,
  input wire logic srst,
  input wire fwe_pkg::fwe_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire fwe_pkg::fwe_mx_req_t mx_req,
  input wire logic busy,
  input wire logic rd_valid,
  input wire logic refused,
  input wire fwe_pkg::fwe_fl_cmd_t fl_cmd,
  input wire logic one_shot_enable,
  input wire logic read_always_enable,
  input wire logic sense_off,
  input wire fwe_pkg::fwe_xram_t xram_wr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_wr_take;
    mx_req.wr && !busy;
  endsequence
  sequence s_one_result;
    $onehot({xram_wr.wr, fl_cmd.prog, fl_cmd.erase, refused});
  endsequence
  a_one_result: assert property (s_wr_take |=> s_one_result)
    else $error("write gave not exactly one outcome");
  a_op_busy: assert property ((fl_cmd.prog || fl_cmd.erase) |-> busy)
    else $error("flash operation without busy");
  a_lock_page: assert property (fl_cmd.erase |->
    fl_cmd.scratch || fl_cmd.addr[15:9] != 7'h7e)
    else $error("lock page erased");
  a_sense_read: assert property (sense_off |-> rd_valid)
    else $error("sense off without read");
  a_read_always: assert property (read_always_enable [*2] |-> fl_cmd.read)
    else $error("read not issued every cycle");
  a_store_rsvd: assert property (sfr_req.rd && sfr_req.page == 4'h0 &&
    sfr_req.addr == 8'h8f |=> sfr_rdata[7:3] == 5'h00)
    else $error("store control upper bits not zero");
  a_ctrl_rsvd: assert property (sfr_req.rd && sfr_req.page == 4'h0 &&
    sfr_req.addr == 8'hb7 |=> sfr_rdata[5:1] == 5'h00)
    else $error("flash control reserved bits not zero");
  a_one_shot_rst: assert property ($fell(srst) |-> one_shot_enable)
    else $error("one shot enable not set after reset");
endmodule : fwe_top_sva
bind fwe_top fwe_top_sva u_sva (.core_clk, .srst, .sfr_req, .sfr_rdata,
  .mx_req, .busy, .rd_valid, .refused, .fl_cmd, .one_shot_enable,
  .read_always_enable, .sense_off, .xram_wr);
`default_nettype wire

/* fwe_flash_model.sv */
// Behavioural flash array answering program, erase and read commands
`timescale 1ns/1ps
`default_nettype none
module fwe_flash_model #(parameter int DLY = 3) (
  input wire logic core_clk,
  input wire fwe_pkg::fwe_fl_cmd_t fl_cmd,
  output logic fl_done = 1'b0,
  output logic fl_rvalid = 1'b0,
  output logic [7:0] fl_rdata = 8'h5a
);
  logic [7:0] mem [0:511];
  int cnt = 0;
  initial mem = '{default: 8'hff};
  always @(posedge core_clk) begin
    fl_done <= cnt == 1;
    cnt <= cnt > 0 ? cnt - 1 : 0;
    fl_rvalid <= fl_cmd.read;
    // Idle data flips so a stale byte never looks valid
    fl_rdata <= fl_cmd.read ? mem[fl_cmd.addr[8:0]] : ~fl_rdata;
    if (fl_cmd.erase || fl_cmd.prog) cnt <= DLY;
    if (fl_cmd.erase) mem <= '{default: 8'hff};
    // Programming only clears bits: unerased bytes come out wrong
    if (fl_cmd.prog) mem[fl_cmd.addr[8:0]] <= mem[fl_cmd.addr[8:0]] & fl_cmd.data;
  end
endmodule : fwe_flash_model
`default_nettype wire

/* fwe_top_bench.sv */
// Self-checking bench for the flash write and erase control block
`timescale 1ns/1ps
`default_nettype none
module fwe_top_bench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  fwe_pkg::fwe_sfr_req_t sfr_req = '0;
  fwe_pkg::fwe_mx_req_t mx_req = '0;
  logic [7:0] sfr_rdata, rd_data, fl_rdata;
  logic busy, rd_valid, refused, fl_done, fl_rvalid, sense_off;
  logic one_shot_enable, read_always_enable;
  fwe_pkg::fwe_fl_cmd_t fl_cmd;
  fwe_pkg::fwe_xram_t xram_wr;
  int err_total = 0;
  int checks_done = 0;
  always #2 core_clk = ~core_clk;
  fwe_top dut (.core_clk, .srst, .sfr_req, .sfr_rdata, .mx_req, .busy,
    .rd_valid, .rd_data, .refused, .fl_cmd, .fl_done, .fl_rvalid,
    .fl_rdata, .one_shot_enable, .read_always_enable, .sense_off,
    .xram_wr);
  fwe_flash_model #(.DLY(3)) u_flash (.core_clk, .fl_cmd, .fl_done,
    .fl_rvalid, .fl_rdata);
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic sfr(logic wr, logic [3:0] pg, logic [7:0] a,
    logic [7:0] d);
    @(negedge core_clk);
    sfr_req = '{wr, ~wr, pg, a, d};
    @(negedge core_clk);
    sfr_req = '0;
  endtask : sfr
  task automatic rd(logic [3:0] pg, logic [7:0] a, logic [7:0] exp);
    sfr(1'b0, pg, a, 8'h00);
    chk("sfr_rdata", {8'h00, exp}, {8'h00, sfr_rdata});
  endtask : rd
  task automatic mx(logic wr, logic [15:0] a, logic [7:0] d,
    logic [15:0] pc);
    @(negedge core_clk);
    mx_req = '{wr, ~wr, a, d, pc};
    @(negedge core_clk);
    mx_req = '0;
  endtask : mx
  // Outcome nibble: erase, program, refused, external RAM write
  task automatic op(logic [15:0] a, logic [7:0] d, logic [15:0] pc,
    logic [3:0] exp);
    mx(1'b1, a, d, pc);
    chk("outcome", {12'h000, exp},
      {12'h000, fl_cmd.erase, fl_cmd.prog, refused, xram_wr.wr});
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge core_clk);
    chk("busy", 16'h0000, {15'h0000, busy});
  endtask : op
  task automatic rdf(logic [15:0] a, logic [15:0] pc, logic [7:0] exp,
    logic so);
    mx(1'b0, a, 8'h00, pc);
    for (int i = 0; i < 20 && rd_valid !== 1'b1; i++) @(negedge core_clk);
    chk("rd_data", {8'h00, exp}, {8'h00, rd_data});
    chk("sense_off", {15'h0000, so}, {15'h0000, sense_off});
  endtask : rdf
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    #4000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    chk("one_shot", 16'h0001, {15'h0000, one_shot_enable});
    rd(4'h0, 8'hb7, 8'h80);
    rd(4'h0, 8'h8f, 8'h00);
    rd(4'hf, 8'hb7, 8'h00);
    rd(4'h0, 8'h10, 8'h00);
    sfr(1'b1, 4'h0, 8'hb7, 8'hc1);
    rd(4'h0, 8'hb7, 8'hc1);
    chk("read_always", 16'h0001, {15'h0000, read_always_enable});
    sfr(1'b1, 4'h0, 8'h8f, 8'hf8);
    rd(4'h0, 8'h8f, 8'h00);
    sfr(1'b1, 4'hf, 8'hb7, 8'h40);
    sfr(1'b1, 4'hf, 8'hb7, 8'h10);
    rd(4'hf, 8'hb7, 8'h40);
    op(16'h4012, 8'h3c, 16'h4000, 4'h1);
    chk("xram_addr", 16'h4012, xram_wr.addr);
    chk("xram_data", 16'h003c, {8'h00, xram_wr.data});
    sfr(1'b1, 4'h0, 8'hb7, 8'h80);
    sfr(1'b1, 4'h0, 8'h8f, 8'h01);
    op(16'h4012, 8'h3c, 16'h4000, 4'h2);
    sfr(1'b1, 4'h0, 8'hb7, 8'h81);
    sfr(1'b1, 4'h0, 8'h8f, 8'h03);
    op(16'hfc00, 8'h00, 16'h4000, 4'h2);
    op(16'h4000, 8'h5e, 16'h4000, 4'h8);
    sfr(1'b1, 4'h0, 8'h8f, 8'h01);
    op(16'h4012, 8'ha5, 16'h4000, 4'h4);
    chk("cmd_data", 16'h00a5, {8'h00, fl_cmd.data});
    op(16'h3fff, 8'h00, 16'h4000, 4'h2);
    rdf(16'h4012, 16'h4000, 8'ha5, 1'b1);
    rdf(16'h3f12, 16'h4000, 8'h00, 1'b0);
    sfr(1'b1, 4'h0, 8'hb7, 8'h01);
    chk("one_shot", 16'h0000, {15'h0000, one_shot_enable});
    rdf(16'h3f12, 16'h3000, 8'hff, 1'b0);
    sfr(1'b1, 4'h0, 8'h8f, 8'h05);
    op(16'h0010, 8'h77, 16'h4000, 4'h4);
    chk("scratch", 16'h0001, {15'h0000, fl_cmd.scratch});
    @(negedge core_clk);
    srst = 1'b1;
    @(negedge core_clk);
    srst = 1'b0;
    chk("one_shot", 16'h0001, {15'h0000, one_shot_enable});
    sfr(1'b1, 4'hf, 8'hb7, 8'h10);
    rd(4'hf, 8'hb7, 8'h10);
    final_report();
  end
endmodule : fwe_top_bench
`default_nettype wire
